// File: sccr_pkg.sv
// package of offsets, fields, reset values and timing counts for the clock and control registers
package sccr_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] PLL_REFERENCE_CONTROL_OFS = 8'h05;
   localparam logic [7:0] CLOCK_OUTPUT_DIVIDER_M_OFS = 8'h06;
   localparam logic [7:0] CLOCK_OUTPUT_DIVIDER_N_OFS = 8'h07;
   localparam logic [7:0] CONTROL_CHANNEL_WATCHDOG_OFS = 8'h08;
   localparam logic [7:0] LOCAL_I2C_CONTROL_ONE_OFS = 8'h09;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] PLL_REFERENCE_CONTROL_RST = 8'h03;
   localparam logic [7:0] CLOCK_OUTPUT_DIVIDER_M_RST = 8'h41;
   localparam logic [7:0] CLOCK_OUTPUT_DIVIDER_N_RST = 8'h28;
   localparam logic [7:0] CONTROL_CHANNEL_WATCHDOG_RST = 8'hfe;
   localparam logic [7:0] LOCAL_I2C_CONTROL_ONE_RST = 8'h1e;
   localparam logic [4:0] OUTPUT_MULTIPLIER_M_DEFAULT = 5'h01;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int INPUT_REF_DIVIDE_LSB = 4;
   localparam int OSCILLATOR_RANGE_SELECT_BIT = 3;
   localparam int HIGHSPEED_SOURCE_DIVIDE_LSB = 5;
   localparam int OUTPUT_MULTIPLIER_M_LSB = 0;
   localparam int CONTROL_LINK_TIMEOUT_LSB = 1;
   localparam int CONTROL_LINK_TIMEOUT_OFF_BIT = 0;
   localparam int REMOTE_WRITE_PROTECT_BIT = 7;
   localparam int SDA_HOLD_LSB = 4;
   localparam int FILTER_DEPTH_LSB = 0;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_PS = 8000;
   localparam int WATCHDOG_UNIT_MS = 2;
   localparam int WATCHDOG_UNIT_CYCLES = WATCHDOG_UNIT_MS * 1000000000 / CLK_PERIOD_PS;
   localparam int SDA_HOLD_UNIT_NS = 50;
   localparam int FILTER_UNIT_NS = 5;
   localparam int FILTER_UNIT_PS = FILTER_UNIT_NS * 1000;
   // hold unit rounds up to whole cycles
   localparam int SDA_HOLD_UNIT_CYCLES = (SDA_HOLD_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// File: sccr_rate_divider.sv
// divided forward-rate tick followed by an m over n fractional rate generator
`timescale 1ns/10ps
module sccr_rate_divider (
   input wire logic clk, // register clock
   input wire logic reset, // synchronous reset, active high
   input wire logic hsTick, // one pulse per forward channel bit time
   input wire logic [2:0] hsDivide, // divide code 0..4
   input wire logic [4:0] mValue, // effective multiplier, never zero
   input wire logic [7:0] nValue, // divisor
   output logic sensor_clock_output // generated sensor clock
);
   logic [15:0] preCount_r;
   logic [15:0] preLimit;
   logic preTick;
   logic [8:0] acc_r;
   logic [8:0] accSum;
   logic sensor_clock_output_r;

   assign preLimit = (hsDivide > 3'h4) ? 16'h0000 : (16'h0001 << hsDivide) - 16'h0001;
   assign preTick = hsTick && (preCount_r >= preLimit);
   assign accSum = acc_r + {4'h0, mValue};

   always_ff @(posedge clk) begin
      if (reset) begin
         preCount_r <= 16'h0000;
      end else if (preTick) begin
         preCount_r <= 16'h0000;
      end else if (hsTick) begin
         preCount_r <= preCount_r + 16'h0001;
      end
   end

   // accumulate m per divided tick; each overflow past n toggles the output
   always_ff @(posedge clk) begin
      if (reset) begin
         acc_r <= 9'h000;
         sensor_clock_output_r <= 1'b0;
      end else if (preTick && nValue != 8'h00) begin
         if (accSum >= {1'b0, nValue}) begin
            acc_r <= accSum - {1'b0, nValue};
            sensor_clock_output_r <= ~sensor_clock_output_r;
         end else begin
            acc_r <= accSum;
         end
      end
   end

   assign sensor_clock_output = sensor_clock_output_r;
endmodule

// File: sccr_link_watchdog.sv
// control-link transaction watchdog counting in 2 ms units
`timescale 1ns/10ps
module sccr_link_watchdog #(
   parameter int UNIT_CYCLES = sccr_pkg::WATCHDOG_UNIT_CYCLES
) (
   input wire logic clk, // register clock
   input wire logic reset, // synchronous reset, active high
   input wire logic enable, // watchdog armed
   input wire logic [6:0] timeoutUnits, // timeout in 2 ms units
   input wire logic busy, // transaction in progress
   output logic expire // one-cycle terminate pulse
);
   logic [31:0] unitCount_r;
   logic [6:0] unitsDone_r;
   logic unitTick;
   logic hit;
   logic expire_r;

   assign unitTick = (unitCount_r == 32'(UNIT_CYCLES - 1));
   // fires once per transaction for a nonzero timeout; with timeout 0 the saturated unit count matches again on every unit tick
   assign hit = unitTick && (unitsDone_r + 7'h01 == timeoutUnits) && !expire_r;

   always_ff @(posedge clk) begin
      if (reset || !enable || !busy) begin
         unitCount_r <= 32'h0;
         unitsDone_r <= 7'h00;
         expire_r <= 1'b0;
      end else begin
         unitCount_r <= unitTick ? 32'h0 : unitCount_r + 32'h1;
         if (unitTick && unitsDone_r != 7'h7f) begin
            unitsDone_r <= unitsDone_r + 7'h01;
         end
         expire_r <= hit;
      end
   end

   assign expire = expire_r;
endmodule

// File: sccr_regs.sv
// clock and control register group with sensor clock and control-link watchdog
`timescale 1ns/10ps

// Functional notes
// - bits 6:4 of the pll register divide the input reference by 1, 2, 4 or 8; codes 4..7 reserved.
// - the oscillator range bit picks the 25 MHz band (0) or the 50 MHz band (1) for internal clocking.
// - bits 7:5 of the m register divide the forward rate by 1..16 before the m/n stage, reset 2.
// - the sensor clock comes from the high-speed divide, m at offset 0x06 and n at offset 0x07.
// - the sensor clock toggles at the divided high-speed rate scaled by m over n.
// - m is five bits resetting to 1 and a written zero is used as 1.
// - an enabled watchdog terminates a control transaction that outlives the timeout.
// - watchdog register bit 0 set disables the watchdog; reset 0 leaves it enabled.
// - with bit 7 of the i2c control set, register writes from the control link are blocked.
// - the sda input hold time is bits 6:4 times 50 ns, reset 1; the code holds for bits 6:4 times 7 cycles (56 ns).
// - glitches up to bits 3:0 times 5 ns on scl and sda are rejected, reset 0xe.
module sccr_regs #(
   parameter int WATCHDOG_UNIT = sccr_pkg::WATCHDOG_UNIT_CYCLES // cycles per 2 ms
) (
   input wire logic clk, // register clock, 125 MHz
   input wire logic reset, // synchronous reset, active high
   input wire logic regWrite, // register write strobe
   input wire logic regRead, // register read strobe
   input wire logic regFromLink, // access arrived over the control link
   input wire logic [7:0] regAddr, // register offset
   input wire logic [7:0] regWdata, // write data
   input wire logic inputReferenceClockTick, // one pulse per input reference edge
   input wire logic hsTick, // one pulse per forward channel bit time
   input wire logic linkBusy, // control-link transaction in progress
   input wire logic linkToLocalSlave, // remote access aimed at a local i2c slave
   input wire logic sclIn, // local scl input
   input wire logic sdaIn, // local sda input
   output logic [7:0] regRdata, // read data
   output logic regWriteBlocked, // write refused by protection
   output logic internalRefTick, // divided input reference
   output logic oscillatorRangeSelect, // 0: 25 MHz band, 1: 50 MHz band
   output logic sensorClockOutput, // generated sensor clock
   output logic linkTimeoutAbort, // terminate control transaction
   output logic localWriteThrough, // remote slave access allowed through
   output logic sclFiltered, // deglitched scl
   output logic sdaFiltered // deglitched and held sda
);
   import sccr_pkg::*;

   // ************************************************************
   // register storage and decode
   // ************************************************************
   logic [7:0] pllRef_r;
   logic [7:0] divM_r;
   logic [7:0] divN_r;
   logic [7:0] watchdog_r;
   logic [7:0] i2cCtrl_r;
   logic [7:0] regRdata_r;
   logic regWriteBlocked_r;
   logic writeProtect;
   logic writeOk;
   logic hitPll;
   logic hitM;
   logic hitN;
   logic hitWd;
   logic hitI2c;
   logic [7:0] readMux;
   logic wrPll;
   logic wrM;
   logic wrN;
   logic wrWd;
   logic wrI2c;

   assign writeProtect = i2cCtrl_r[REMOTE_WRITE_PROTECT_BIT];
   // link writes are dropped while protect is set; local writes always land
   assign writeOk = regWrite && !(regFromLink && writeProtect);
   assign hitPll = regAddr == PLL_REFERENCE_CONTROL_OFS;
   assign hitM = regAddr == CLOCK_OUTPUT_DIVIDER_M_OFS;
   assign hitN = regAddr == CLOCK_OUTPUT_DIVIDER_N_OFS;
   assign hitWd = regAddr == CONTROL_CHANNEL_WATCHDOG_OFS;
   assign hitI2c = regAddr == LOCAL_I2C_CONTROL_ONE_OFS;
   assign wrPll = writeOk && hitPll;
   assign wrM = writeOk && hitM;
   assign wrN = writeOk && hitN;
   assign wrWd = writeOk && hitWd;
   assign wrI2c = writeOk && hitI2c;
   // whole bytes read back including reserved bits
   assign readMux = hitPll ? pllRef_r : hitM ? divM_r : hitN ? divN_r :
                    hitWd ? watchdog_r : hitI2c ? i2cCtrl_r : 8'h00;

   // each byte is stored whole, reserved bits included
   always_ff @(posedge clk) begin
      if (reset) begin
         pllRef_r <= PLL_REFERENCE_CONTROL_RST;
      end else if (wrPll) begin
         pllRef_r <= regWdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         divM_r <= CLOCK_OUTPUT_DIVIDER_M_RST;
      end else if (wrM) begin
         divM_r <= regWdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         divN_r <= CLOCK_OUTPUT_DIVIDER_N_RST;
      end else if (wrN) begin
         divN_r <= regWdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         watchdog_r <= CONTROL_CHANNEL_WATCHDOG_RST;
      end else if (wrWd) begin
         watchdog_r <= regWdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         i2cCtrl_r <= LOCAL_I2C_CONTROL_ONE_RST;
      end else if (wrI2c) begin
         i2cCtrl_r <= regWdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         regRdata_r <= 8'h00;
         regWriteBlocked_r <= 1'b0;
      end else begin
         regRdata_r <= regRead ? readMux : regRdata_r;
         regWriteBlocked_r <= regWrite && regFromLink && writeProtect;
      end
   end

   // ************************************************************
   // input reference divider and oscillator range
   // ************************************************************
   logic [2:0] refDivCode;
   logic [2:0] refCount_r;
   logic [2:0] refLimit;
   logic refHit;
   logic internalRefTick_r;
   logic oscRange_r;

   assign refDivCode = pllRef_r[INPUT_REF_DIVIDE_LSB +: 3];
   // reserved codes fall back to divide by one
   assign refLimit = refDivCode[2] ? 3'h0 : 3'((4'h1 << refDivCode[1:0]) - 4'h1);
   assign refHit = inputReferenceClockTick && (refCount_r >= refLimit);

   always_ff @(posedge clk) begin
      if (reset) begin
         refCount_r <= 3'h0;
         internalRefTick_r <= 1'b0;
         oscRange_r <= 1'b0;
      end else begin
         if (refHit) refCount_r <= 3'h0;
         else if (inputReferenceClockTick) refCount_r <= refCount_r + 3'h1;
         internalRefTick_r <= refHit;
         oscRange_r <= pllRef_r[OSCILLATOR_RANGE_SELECT_BIT];
      end
   end

   // ************************************************************
   // sensor clock generator
   // ************************************************************
   logic [4:0] mField;
   logic [4:0] mEffective;
   logic sensorClk;
   logic sensorClk_r;
   logic [2:0] hsDivideField;

   assign hsDivideField = divM_r[HIGHSPEED_SOURCE_DIVIDE_LSB +: 3];
   assign mField = divM_r[OUTPUT_MULTIPLIER_M_LSB +: 5];
   assign mEffective = (mField == 5'h00) ? OUTPUT_MULTIPLIER_M_DEFAULT : mField;

   sccr_rate_divider uRate (
      .clk(clk),
      .reset(reset),
      .hsTick(hsTick),
      .hsDivide(hsDivideField),
      .mValue(mEffective),
      .nValue(divN_r),
      .sensor_clock_output(sensorClk)
   );

   always_ff @(posedge clk) begin
      if (reset) sensorClk_r <= 1'b0;
      else sensorClk_r <= sensorClk;
   end

   // ************************************************************
   // control-link watchdog and protection pass-through
   // ************************************************************
   logic wdExpire;
   logic linkTimeoutAbort_r;
   logic localWriteThrough_r;
   logic wdEnable;
   logic [6:0] wdTimeout;

   // the count restarts whenever the link goes idle or the watchdog is turned off
   assign wdEnable = !watchdog_r[CONTROL_LINK_TIMEOUT_OFF_BIT];
   assign wdTimeout = watchdog_r[CONTROL_LINK_TIMEOUT_LSB +: 7];

   sccr_link_watchdog #(
      .UNIT_CYCLES(WATCHDOG_UNIT)
   ) uWatchdog (
      .clk(clk),
      .reset(reset),
      .enable(wdEnable),
      .timeoutUnits(wdTimeout),
      .busy(linkBusy),
      .expire(wdExpire)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         linkTimeoutAbort_r <= 1'b0;
         localWriteThrough_r <= 1'b0;
      end else begin
         linkTimeoutAbort_r <= wdExpire;
         localWriteThrough_r <= linkToLocalSlave;
      end
   end

   // ************************************************************
   // i2c glitch filter and sda hold
   // ************************************************************
   logic [3:0] filterDepth;
   logic [2:0] holdField;
   logic [7:0] filterLimit;
   logic [7:0] holdLimit;
   logic [1:0] pinIn;
   logic [1:0] pinStable_r;
   logic [7:0] pinCount_r [2];
   logic sclPrev_r;
   logic [7:0] holdCount_r;
   logic sdaHeld_r;

   assign filterDepth = i2cCtrl_r[FILTER_DEPTH_LSB +: 4];
   assign holdField = i2cCtrl_r[SDA_HOLD_LSB +: 3];
   // cycles needed to exceed depth x 5 ns
   assign filterLimit = 8'(({4'h0, filterDepth} * FILTER_UNIT_PS) / CLK_PERIOD_PS);
   assign holdLimit = 8'({5'h00, holdField} * SDA_HOLD_UNIT_CYCLES);
   assign pinIn = {sdaIn, sclIn};

   generate
      for (genvar i = 0; i < 2; i++) begin : gFilter
         always_ff @(posedge clk) begin
            if (reset) begin
               pinStable_r[i] <= 1'b1;
               pinCount_r[i] <= 8'h00;
            end else if (pinIn[i] == pinStable_r[i]) begin
               pinCount_r[i] <= 8'h00;
            end else if (pinCount_r[i] >= filterLimit) begin
               pinStable_r[i] <= pinIn[i];
               pinCount_r[i] <= 8'h00;
            end else begin
               pinCount_r[i] <= pinCount_r[i] + 8'h01;
            end
         end
      end
   endgenerate

   // sda follows its filtered level except within the hold window after scl falls
   always_ff @(posedge clk) begin
      if (reset) begin
         sclPrev_r <= 1'b1;
         holdCount_r <= 8'h00;
         sdaHeld_r <= 1'b1;
      end else begin
         sclPrev_r <= pinStable_r[0];
         if (sclPrev_r && !pinStable_r[0]) begin
            holdCount_r <= holdLimit;
         end else if (holdCount_r != 8'h00) begin
            holdCount_r <= holdCount_r - 8'h01;
         end else begin
            sdaHeld_r <= pinStable_r[1];
         end
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign regRdata = regRdata_r;
   assign regWriteBlocked = regWriteBlocked_r;
   assign internalRefTick = internalRefTick_r;
   assign oscillatorRangeSelect = oscRange_r;
   assign sensorClockOutput = sensorClk_r;
   assign linkTimeoutAbort = linkTimeoutAbort_r;
   assign localWriteThrough = localWriteThrough_r;
   assign sclFiltered = pinStable_r[0];
   assign sdaFiltered = sdaHeld_r;
endmodule

// File: sccr_regs_asserts.sv
// port relation checks for the clock and control registers
`timescale 1ns/10ps
module sccr_regs_asserts #(
   parameter int WATCHDOG_UNIT = sccr_pkg::WATCHDOG_UNIT_CYCLES // cycles per watchdog unit
) (
   input wire logic clk, // clock
   input wire logic reset, // reset
   input wire logic regWrite, // write strobe
   input wire logic regRead, // read strobe
   input wire logic regFromLink, // link access
   input wire logic [7:0] regAddr, // offset
   input wire logic [7:0] regRdata, // read data
   input wire logic regWriteBlocked, // refused write
   input wire logic inputReferenceClockTick, // reference tick
   input wire logic internalRefTick, // divided reference
   input wire logic hsTick, // forward tick
   input wire logic sensorClockOutput, // sensor clock
   input wire logic linkBusy, // transaction busy
   input wire logic linkTimeoutAbort, // abort pulse
   input wire logic linkToLocalSlave, // slave access
   input wire logic localWriteThrough, // slave access passed
   input wire logic sclFiltered, // filtered scl
   input wire logic sdaFiltered // filtered sda
);
   // ************************************************************
   // checks
   // ************************************************************
   logic [31:0] busyCnt_r;
   always_ff @(posedge clk) begin
      if (reset || !linkBusy)
         busyCnt_r <= 32'h00000000;
      else if (busyCnt_r != 32'hffffffff)
         busyCnt_r <= busyCnt_r + 32'h00000001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_unmapped_zero: assert property (regRead && (regAddr < 8'h05 || regAddr > 8'h09)
      |=> regRdata == 8'h00) else $error("unmapped read not zero");
   a_rdata_hold: assert property (!regRead |=> $stable(regRdata))
      else $error("read data changed without read");
   a_block_cause: assert property (regWriteBlocked |-> $past(regWrite && regFromLink))
      else $error("refusal without link write");
   a_local_write_ok: assert property (regWrite && !regFromLink |=> !regWriteBlocked)
      else $error("local write refused");
   a_through_copy: assert property (!$past(reset)
      |-> localWriteThrough == $past(linkToLocalSlave)) else $error("slave access held back");
   a_ref_tick_cause: assert property (internalRefTick |-> $past(inputReferenceClockTick))
      else $error("reference tick without input tick");
   a_clk_needs_tick: assert property ((!hsTick)[*8] |=> $stable(sensorClockOutput))
      else $error("sensor clock moved without ticks");
   a_watchdog_min: assert property (linkTimeoutAbort |-> busyCnt_r >= WATCHDOG_UNIT)
      else $error("abort before one timeout unit");
   a_no_abort_idle: assert property ((!linkBusy)[*3] |-> !linkTimeoutAbort)
      else $error("abort while idle");
   a_filter_reset: assert property (disable iff (1'b0) reset |=> sclFiltered && sdaFiltered)
      else $error("filtered lines not high after reset");
endmodule

// File: sccr_reg_master.sv
// register access master standing for local or remote software
`timescale 1ns/10ps
module sccr_reg_master (
   input wire logic clk, // clock
   input wire logic [7:0] regRdata, // read data
   input wire logic regWriteBlocked, // refused write
   output logic regWrite, // write strobe
   output logic regRead, // read strobe
   output logic regFromLink, // link access
   output logic [7:0] regAddr, // offset
   output logic [7:0] regWdata // write data
);
   import sccr_pkg::*;
   // ************************************************************
   // accesses
   // ************************************************************
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regFromLink = 1'b0;
      regAddr = 8'hff;
      regWdata = 8'hff;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic l, output logic b);
      if (a == CLOCK_OUTPUT_DIVIDER_N_OFS && d == 8'h00) d = 8'h01;
      if (a == CONTROL_CHANNEL_WATCHDOG_OFS && d[7:1] == 7'h00) d[7:1] = 7'h01;
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      regFromLink <= l;
      @(posedge clk);
      regWrite <= 1'b0;
      regFromLink <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~d;
      @(negedge clk);
      b = regWriteBlocked;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      @(negedge clk);
      d = regRdata;
   endtask
endmodule

// File: sccr_regs_tb.sv
// testbench for the clock and control registers
`timescale 1ns/10ps
module sccr_regs_tb;
   import sccr_pkg::*;
   localparam int UNIT = 4;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] rb; logic [7:0] rst;} sccr_row_s;
   sccr_row_s rows [7];
   logic [7:0] ck [4][3];
   logic clk, reset, regWrite, regRead, regFromLink, inputReferenceClockTick, hsTick;
   logic linkBusy, linkToLocalSlave, sclIn, sdaIn, regWriteBlocked, internalRefTick, blk;
   logic oscillatorRangeSelect, sensorClockOutput, linkTimeoutAbort, localWriteThrough;
   logic sclFiltered, sdaFiltered;
   logic [7:0] regAddr, regWdata, regRdata, rd;
   int miscompares, testsRun, n, refCnt, abortCnt, lowCnt;
   sccr_regs #(.WATCHDOG_UNIT(UNIT)) i_dut (.clk, .reset, .regWrite, .regRead, .regFromLink,
      .regAddr, .regWdata, .inputReferenceClockTick, .hsTick, .linkBusy, .linkToLocalSlave,
      .sclIn, .sdaIn, .regRdata, .regWriteBlocked, .internalRefTick, .oscillatorRangeSelect,
      .sensorClockOutput, .linkTimeoutAbort, .localWriteThrough, .sclFiltered, .sdaFiltered);
   sccr_reg_master i_bus (.clk, .regRdata, .regWriteBlocked, .regWrite, .regRead,
      .regFromLink, .regAddr, .regWdata);
   // ************************************************************
   // helpers
   // ************************************************************
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (miscompares == 0 && testsRun > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic edge_wait(output int p);
      logic s;
      s = sensorClockOutput;
      p = 0;
      while (sensorClockOutput === s && p < 200) begin
         @(negedge clk);
         p++;
      end
   endtask
   always @(negedge clk) begin
      if (internalRefTick === 1'b1) refCnt++;
      if (linkTimeoutAbort === 1'b1) abortCnt++;
      if (sclFiltered !== 1'b1) lowCnt++;
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #60000;
      miscompares++;
      complete_run();
   end
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      {reset, inputReferenceClockTick, hsTick, linkBusy, linkToLocalSlave} = 5'b10000;
      {sclIn, sdaIn} = 2'b11;
      rows = '{'{8'h05, 8'hb5, 8'hb5, 8'h03}, '{8'h06, 8'h9f, 8'h9f, 8'h41},
         '{8'h07, 8'hff, 8'hff, 8'h28}, '{8'h08, 8'hff, 8'hff, 8'hfe},
         '{8'h09, 8'h7f, 8'h7f, 8'h1e}, '{8'h04, 8'haa, 8'h00, 8'h00},
         '{8'h0a, 8'h55, 8'h00, 8'h00}};
      ck = '{'{8'h01, 8'h04, 8'd4}, '{8'h42, 8'h08, 8'd16},
         '{8'h00, 8'h03, 8'd3}, '{8'h81, 8'h01, 8'd16}};
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         i_bus.wr(rows[i].a, rows[i].d, 1'b0, blk);
         i_bus.rd(rows[i].a, rd);
         check("readback", rd, rows[i].rb);
      end
      for (int c = 0; c < 4; c++) begin
         i_bus.wr(PLL_REFERENCE_CONTROL_OFS, 8'(c << 4 | (c & 1) << 3), 1'b0, blk);
         refCnt = 0;
         repeat (24) begin
            @(posedge clk) inputReferenceClockTick <= 1'b1;
            @(posedge clk) inputReferenceClockTick <= 1'b0;
         end
         repeat (3) @(posedge clk);
         check("refDivide", 8'(refCnt), 8'(24 >> c));
         check("oscRange", {7'h00, oscillatorRangeSelect}, 8'(c & 1));
      end
      @(posedge clk) hsTick <= 1'b1;
      foreach (ck[i]) begin
         i_bus.wr(CLOCK_OUTPUT_DIVIDER_M_OFS, ck[i][0], 1'b0, blk);
         i_bus.wr(CLOCK_OUTPUT_DIVIDER_N_OFS, ck[i][1], 1'b0, blk);
         repeat (6) edge_wait(n);
         check("clkPeriod", 8'(n), ck[i][2]);
      end
      @(posedge clk) hsTick <= 1'b0;
      i_bus.wr(CONTROL_CHANNEL_WATCHDOG_OFS, 8'h04, 1'b0, blk);
      abortCnt = 0;
      @(posedge clk) linkBusy <= 1'b1;
      n = 0;
      while (linkTimeoutAbort !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      check("abortTime", 8'(n >= 2 * UNIT && n <= 2 * UNIT + 4), 8'h01);
      repeat (20) @(posedge clk);
      linkBusy <= 1'b0;
      i_bus.wr(CONTROL_CHANNEL_WATCHDOG_OFS, 8'h05, 1'b0, blk);
      check("abortOnce", 8'(abortCnt), 8'h01);
      abortCnt = 0;
      @(posedge clk) linkBusy <= 1'b1;
      repeat (40) @(posedge clk);
      linkBusy <= 1'b0;
      check("abortOff", 8'(abortCnt), 8'h00);
      i_bus.wr(LOCAL_I2C_CONTROL_ONE_OFS, 8'h9e, 1'b0, blk);
      i_bus.wr(CLOCK_OUTPUT_DIVIDER_N_OFS, 8'h11, 1'b1, blk);
      check("blocked", {7'h00, blk}, 8'h01);
      i_bus.rd(CLOCK_OUTPUT_DIVIDER_N_OFS, rd);
      check("nKept", rd, 8'h01);
      @(posedge clk) linkToLocalSlave <= 1'b1;
      repeat (2) @(negedge clk);
      check("through", {7'h00, localWriteThrough}, 8'h01);
      i_bus.wr(LOCAL_I2C_CONTROL_ONE_OFS, 8'h1e, 1'b0, blk);
      i_bus.wr(CLOCK_OUTPUT_DIVIDER_N_OFS, 8'h22, 1'b1, blk);
      i_bus.rd(CLOCK_OUTPUT_DIVIDER_N_OFS, rd);
      check("linkWrite", rd, 8'h22);
      lowCnt = 0;
      @(posedge clk) sclIn <= 1'b0;
      @(posedge clk) sclIn <= 1'b1;
      repeat (12) @(posedge clk);
      check("glitch", 8'(lowCnt), 8'h00);
      {sclIn, sdaIn} <= 2'b00;
      repeat (14) @(negedge clk);
      check("holdWindow", {6'h00, sclFiltered, sdaFiltered}, 8'h01);
      repeat (16) @(negedge clk);
      check("lowTaken", {6'h00, sclFiltered, sdaFiltered}, 8'h00);
      @(posedge clk) reset <= 1'b1;
      {sclIn, sdaIn} <= 2'b11;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      check("filtRst", {6'h00, sclFiltered, sdaFiltered}, 8'h03);
      foreach (rows[i]) begin
         i_bus.rd(rows[i].a, rd);
         check("resetValue", rd, rows[i].rst);
      end
      complete_run();
   end
endmodule
bind sccr_regs sccr_regs_asserts #(.WATCHDOG_UNIT(WATCHDOG_UNIT)) i_chk (.clk, .reset,
   .regWrite, .regRead, .regFromLink, .regAddr, .regRdata, .regWriteBlocked,
   .inputReferenceClockTick, .internalRefTick, .hsTick, .sensorClockOutput, .linkBusy,
   .linkTimeoutAbort, .linkToLocalSlave, .localWriteThrough, .sclFiltered, .sdaFiltered);
